// ===== hdl/lcdmx_driver.sv
/*
  lcdmx_driver: 16x8 display ram, address pointer, duty/bias selection, common
  scan, segment data, blink and frame rate for a multiplexed lcd.
  assumes an apb master on pclk; analog drive levels are outside this block,
  which hands out the selected common, the segment data bits and the bias switch.
*/
// The implementer's own choices: the APB register port and the address map.
// Functional notes
// - outputs held at full drive until display, oscillator and bias generator on
// - reset selects four commons, third bias
// - oscillator, bias generator, display off at reset
// - reset: vadj on, shared pin segment, detect off
// - reset: 80 hz frame, blinking off
// - sixteen byte ram, one means segment on
// - quarter duty: nibble per even/odd segment
// - eighth duty: byte k drives segment k+4
// - twenty segments, or sixteen in eighth duty
// - four or eight commons per mode
// - segment from latched bit of scanned common
// - quarter duty third bias, eighth quarter bias
// - third bias bypasses divider centre element
// - all timing divided from system oscillator
// - ram written through host-set address pointer
// - blink modes divide fsys 16384/32768/65536
// - frame rate 80 hz or 160 hz
// - data byte bits map unchanged
// - pointer increments, wraps past last location
`timescale 1ns/1ps
`default_nettype none
module lcdmx_driver #(
  parameter int FSYS_DIV = lcdmx_pkg::LCDMX_FSYS_DIV
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output lcdmx_pkg::lcdmx_drive_type drive,
  output logic [19:0] segment_outputs,
  output logic [7:0] common_outputs,
  output logic full_scale_drive_voltage,
  output logic lcd_drive_voltage_pin
);
  import lcdmx_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    lcdmx_ctrl_type ctrl;
    logic [3:0] ptr;
    logic [12:0] fsys_cnt;
    logic fsys_tick;
    logic [16:0] blink_cnt;
    logic [7:0] frame_cnt;
    logic [2:0] com_idx;
    logic [31:0] rdata;
    lcdmx_drive_type drv;
  } lcdmx_state_type;

  lcdmx_state_type r;
  lcdmx_state_type next_r;
  logic [7:0] ram [LCDMX_RAM_WORDS];

  logic wr_en;
  logic rd_en;
  logic [3:0] last_addr;
  logic [7:0] frame_steps;
  logic blink_phase;
  logic [19:0] seg_bits;
  logic [7:0] com_bits;
  logic [7:0] com_mask;
  // each blink half period is the top bit of a counter of fsys ticks
  localparam int BLINK1_BIT = $clog2(LCDMX_BLINK1_DIV) - 1;
  localparam int BLINK2_BIT = $clog2(LCDMX_BLINK2_DIV) - 1;
  localparam int BLINK3_BIT = $clog2(LCDMX_BLINK3_DIV) - 1;

  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign last_addr = r.ctrl.duty8 ? LCDMX_LAST_ADDR_E : LCDMX_LAST_ADDR_Q;

  // ****************************************
  // display ram
  // ****************************************
  // ram holds no reset so it maps to a plain array; contents undefined until written
  always_ff @(posedge pclk) begin
    if (wr_en && paddr == LCDMX_DATA_OFF) begin
      ram[r.ptr] <= pwdata[7:0];
    end
  end

  // ****************************************
  // segment and common mapping
  // ****************************************
  always_comb begin
    seg_bits = '0;
    com_mask = r.ctrl.duty8 ? 8'hFF : 8'h0F;
    com_bits = 8'h00;
    com_bits[r.com_idx] = 1'b1;
    for (int n = 0; n < 10; n++) begin
      if (!r.ctrl.duty8) begin
        seg_bits[2 * n] = ram[n][r.com_idx[1:0]];
        seg_bits[2 * n + 1] = ram[n][4 + r.com_idx[1:0]];
      end
    end
    for (int k = 0; k < 16; k++) begin
      if (r.ctrl.duty8) begin
        seg_bits[k + 4] = ram[k][r.com_idx];
      end
    end
  end

  // blink phase is the top bit of the selected divider
  always_comb begin
    case (r.ctrl.blink_mode)
      2'd1: blink_phase = r.blink_cnt[BLINK1_BIT];
      2'd2: blink_phase = r.blink_cnt[BLINK2_BIT];
      2'd3: blink_phase = r.blink_cnt[BLINK3_BIT];
      default: blink_phase = 1'b0;
    endcase
  end

  // fsys ticks per common step: fsys / (frame * commons)
  always_comb begin
    if (r.ctrl.duty8) begin
      frame_steps = r.ctrl.frame160 ? 8'(LCDMX_FSYS_HZ / (LCDMX_FRAME160_HZ * 8))
                                    : 8'(LCDMX_FSYS_HZ / (LCDMX_FRAME80_HZ * 8));
    end else begin
      frame_steps = r.ctrl.frame160 ? 8'(LCDMX_FSYS_HZ / (LCDMX_FRAME160_HZ * 4))
                                    : 8'(LCDMX_FSYS_HZ / (LCDMX_FRAME80_HZ * 4));
    end
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_r = r;
    next_r.fsys_tick = 1'b0;
    // fsys derived from pclk, runs only with oscillator on
    if (r.ctrl.osc_on) begin
      if (r.fsys_cnt == 13'(FSYS_DIV - 1)) begin
        next_r.fsys_cnt = '0;
        next_r.fsys_tick = 1'b1;
      end else begin
        next_r.fsys_cnt = r.fsys_cnt + 13'd1;
      end
    end
    if (r.fsys_tick) begin
      next_r.blink_cnt = r.blink_cnt + 17'd1;
      if (r.frame_cnt >= frame_steps - 8'd1) begin
        next_r.frame_cnt = '0;
        // ascending scan, wraps after last active common
        if ((r.ctrl.duty8 && r.com_idx == 3'd7) || (!r.ctrl.duty8 && r.com_idx == 3'd3)) begin
          next_r.com_idx = '0;
        end else begin
          next_r.com_idx = r.com_idx + 3'd1;
        end
      end else begin
        next_r.frame_cnt = r.frame_cnt + 8'd1;
      end
    end
    if (wr_en) begin
      if (paddr == LCDMX_CTRL_OFF) begin
        next_r.ctrl = lcdmx_ctrl_type'(pwdata[9:0]);
        if (pwdata[LCDMX_DUTY8_BIT] != r.ctrl.duty8) begin
          next_r.com_idx = '0;
          next_r.ptr = '0;
        end
      end else if (paddr == LCDMX_PTR_OFF) begin
        next_r.ptr = (pwdata[3:0] > last_addr) ? 4'h0 : pwdata[3:0];
      end else if (paddr == LCDMX_DATA_OFF) begin
        next_r.ptr = (r.ptr == last_addr) ? 4'h0 : r.ptr + 4'd1;
      end
    end
    if (rd_en && paddr == LCDMX_DATA_OFF) begin
      next_r.ptr = (r.ptr == last_addr) ? 4'h0 : r.ptr + 4'd1;
    end
    next_r.rdata = '0;
    if (psel && !penable) begin
      if (paddr == LCDMX_CTRL_OFF) begin
        next_r.rdata = {22'h0, r.ctrl};
      end else if (paddr == LCDMX_PTR_OFF) begin
        next_r.rdata = {28'h0, r.ptr};
      end else if (paddr == LCDMX_DATA_OFF) begin
        next_r.rdata = {24'h0, ram[r.ptr]};
      end else if (paddr == LCDMX_STATUS_OFF) begin
        next_r.rdata = {27'h0, blink_phase, r.fsys_tick, r.com_idx};
      end
    end
    // drive outputs: all at full level until display, oscillator and bias generator run
    if (!(r.ctrl.display_on && r.ctrl.osc_on && r.ctrl.bias_gen_on)) begin
      next_r.drv.seg = '1;
      next_r.drv.com = '1;
      next_r.drv.blank = 1'b1;
    end else begin
      next_r.drv.com = com_bits & com_mask;
      next_r.drv.seg = blink_phase ? '0 : seg_bits;
      if (r.ctrl.duty8) begin
        next_r.drv.seg[3:0] = 4'h0;
      end
      next_r.drv.blank = 1'b0;
    end
    next_r.drv.com_active = com_mask;
    next_r.drv.bias_third = !r.ctrl.duty8;
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.ctrl <= lcdmx_ctrl_type'(LCDMX_CTRL_RESET);
      r.drv.seg <= '1;
      r.drv.com <= '1;
      r.drv.com_active <= 8'h0F;
      r.drv.bias_third <= 1'b1;
      r.drv.blank <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign prdata = r.rdata;
  assign drive = r.drv;
  assign segment_outputs = r.drv.seg;
  assign common_outputs = r.drv.com;
  // high means full drive level present on all outputs
  assign full_scale_drive_voltage = r.drv.blank;
  // shared pin acts as lcd_drive_voltage_pin only when selected
  assign lcd_drive_voltage_pin = r.ctrl.shared_is_lcd_drive_voltage_pin;
endmodule
`default_nettype wire

// ===== pkg/lcdmx_pkg.sv
/*
  lcdmx_pkg: register map, field layout, reset values and timing counts for the
  multiplexed lcd display ram and drive sequencer.
  assumes an apb master on pclk and a 125 MHz pclk.
*/
`default_nettype none
package lcdmx_pkg;
  // ****************************************
  // register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] LCDMX_CTRL_OFF = 8'h00;
  localparam logic [7:0] LCDMX_PTR_OFF = 8'h04;
  localparam logic [7:0] LCDMX_DATA_OFF = 8'h08;
  localparam logic [7:0] LCDMX_STATUS_OFF = 8'h0C;
  // ****************************************
  // control field positions
  // ****************************************
  localparam int LCDMX_OSC_BIT = 0;
  localparam int LCDMX_BIAS_GEN_BIT = 1;
  localparam int LCDMX_DISP_BIT = 2;
  localparam int LCDMX_DUTY8_BIT = 3;
  localparam int LCDMX_FRAME160_BIT = 4;
  localparam int LCDMX_BLINK_LSB = 5;
  localparam int LCDMX_VADJ_BIT = 7;
  localparam int LCDMX_SHARED_LCD_DRIVE_VOLTAGE_PIN_BIT = 8;
  localparam int LCDMX_DETECT_BIT = 9;
  localparam logic [9:0] LCDMX_CTRL_RESET = 10'h080;
  // ****************************************
  // memory geometry
  // ****************************************
  localparam int LCDMX_RAM_WORDS = 16;
  localparam logic [3:0] LCDMX_LAST_ADDR_Q = 4'h9;
  localparam logic [3:0] LCDMX_LAST_ADDR_E = 4'hF;
  localparam int LCDMX_SEGS = 20;
  localparam int LCDMX_COMS = 8;
  // ****************************************
  // timing: system clock of the lcd logic
  // ****************************************
  localparam int LCDMX_PCLK_HZ = 125000000;
  localparam int LCDMX_FSYS_HZ = 32768;
  localparam int LCDMX_FSYS_DIV = LCDMX_PCLK_HZ / LCDMX_FSYS_HZ;
  localparam int LCDMX_FRAME80_HZ = 80;
  localparam int LCDMX_FRAME160_HZ = 160;
  localparam int LCDMX_BLINK1_DIV = 16384;
  localparam int LCDMX_BLINK2_DIV = 32768;
  localparam int LCDMX_BLINK3_DIV = 65536;

  typedef struct packed {
    logic detect_switch;
    logic shared_is_lcd_drive_voltage_pin;
    logic vadj_enable;
    logic [1:0] blink_mode;
    logic frame160;
    logic duty8;
    logic display_on;
    logic bias_gen_on;
    logic osc_on;
  } lcdmx_ctrl_type;

  typedef struct packed {
    logic [19:0] seg;
    logic [7:0] com;
    logic [7:0] com_active;
    logic bias_third;
    logic blank;
  } lcdmx_drive_type;
endpackage
`default_nettype wire

// ===== verification/lcdmx_panel.sv
/* lcdmx_panel: passive glass model, one latched pixel per common and segment.
   assumes one-hot common outputs while the display runs. */
`timescale 1ns/1ps
`default_nettype none
module lcdmx_panel (
  input wire logic pclk,
  input wire logic [19:0] seg,
  input wire logic [7:0] com,
  output logic [159:0] pix
);
  // a pixel only sees its segment while its common is selected;
  // full-drive all-high states are not a scan and leave the image alone
  always_ff @(posedge pclk) begin
    for (int i = 0; i < 8; i++) begin
      if ($onehot(com) && com[i]) begin
        pix[i*20 +: 20] <= seg;
      end
    end
  end
endmodule
`default_nettype wire

// ===== verification/lcdmx_driver_sva.sv
/* lcdmx_driver_sva: port checks of lcdmx_driver.
   assumes pclk and presetn come from the bench. */
`timescale 1ns/1ps
`default_nettype none
module lcdmx_driver_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pready,
  input wire logic pslverr,
  input wire lcdmx_pkg::lcdmx_drive_type drive,
  input wire logic [19:0] segment_outputs,
  input wire logic [7:0] common_outputs,
  input wire logic full_scale_drive_voltage,
  input wire logic lcd_drive_voltage_pin
);
  import lcdmx_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ****************************************
  // properties
  // ****************************************
  sequence s_step;
    !full_scale_drive_voltage && !$past(full_scale_drive_voltage)
      && common_outputs != $past(common_outputs);
  endsequence
  property p_hold;
    full_scale_drive_voltage |-> common_outputs == 8'hFF && segment_outputs == 20'hFFFFF;
  endproperty
  property p_boot;
    $rose(presetn) |-> full_scale_drive_voltage && drive.com_active == 8'h0F
      && drive.bias_third && !lcd_drive_voltage_pin;
  endproperty
  property p_mode;
    drive.com_active == 8'h0F || drive.com_active == 8'hFF;
  endproperty
  property p_bias;
    drive.bias_third == (drive.com_active == 8'h0F);
  endproperty
  property p_mask;
    !full_scale_drive_voltage |-> $onehot(common_outputs)
      && (common_outputs & ~drive.com_active) == 8'h00;
  endproperty
  property p_scan;
    s_step |-> common_outputs == 8'h01 || common_outputs == ($past(common_outputs) << 1);
  endproperty
  // a scan restart after a duty change may land early, so 01 is let through
  property p_dwell;
    s_step |=> (full_scale_drive_voltage || $stable(common_outputs)
      || common_outputs == 8'h01) [*3];
  endproperty
  property p_apb;
    pready && !pslverr;
  endproperty
  a_hold: assert property (p_hold) else $error("outputs not at full drive");
  a_boot: assert property (p_boot) else $error("bad state after reset");
  a_mode: assert property (p_mode) else $error("bad common set");
  a_bias: assert property (p_bias) else $error("bias not paired with duty");
  a_mask: assert property (p_mask) else $error("inactive common selected");
  a_scan: assert property (p_scan) else $error("commons not ascending");
  a_dwell: assert property (p_dwell) else $error("common step too short");
  a_apb: assert property (p_apb) else $error("apb answer wrong");
endmodule
bind lcdmx_driver lcdmx_driver_sva u_sva (
  .pclk(pclk),
  .presetn(presetn),
  .pready(pready),
  .pslverr(pslverr),
  .drive(drive),
  .segment_outputs(segment_outputs),
  .common_outputs(common_outputs),
  .full_scale_drive_voltage(full_scale_drive_voltage),
  .lcd_drive_voltage_pin(lcd_drive_voltage_pin)
);
`default_nettype wire

// ===== verification/lcdmx_driver_tb_top.sv
/* lcdmx_driver_tb_top: apb tests of the lcd driver against a panel model.
   assumes the design with FSYS_DIV shortened to 4. */
`timescale 1ns/1ps
`default_nettype none
module lcdmx_driver_tb_top;
  import lcdmx_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, fs, vpin;
  logic [7:0] paddr, com;
  logic [31:0] pwdata, prdata, rd;
  logic [19:0] seg;
  logic [159:0] pix;
  logic [7:0] ram [16];
  lcdmx_drive_type drive;
  int err_count = 0;
  int check_count = 0;
  int p80, p160, p8;
  initial begin
    pclk = 0;
    forever #4 pclk = ~pclk;
  end
  lcdmx_driver #(.FSYS_DIV(4)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .drive(drive), .segment_outputs(seg),
    .common_outputs(com), .full_scale_drive_voltage(fs), .lcd_drive_voltage_pin(vpin));
  lcdmx_panel u_panel (.pclk(pclk), .seg(seg), .com(com), .pix(pix));
  // ****************************************
  // tasks
  // ****************************************
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  // idle edge first so psel is never assigned twice in one step
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    psel <= 0;
    penable <= 0;
  endtask
  task frame(output int n);
    longint t;
    @(posedge com[0]);
    t = $time;
    @(posedge com[0]);
    n = int'(($time - t) / 8);
  endtask
  task report_and_stop;
    if (err_count == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge pclk);
    err_count++;
    report_and_stop;
  end
  // ****************************************
  // tests
  // ****************************************
  initial begin
    presetn = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    chk("outputs", 32'h1FFFFF, {fs, seg});
    chk("pin", 0, vpin);
    // host wait after power-up, scaled down: reset here is complete at release
    repeat (2) @(posedge pclk);
    xfer(0, LCDMX_CTRL_OFF, 0);
    chk("ctrl", 32'h80, rd);
    xfer(1, 8'h10, 32'hFF);
    xfer(0, 8'h10, 0);
    chk("unmapped", 0, rd);
    xfer(1, LCDMX_PTR_OFF, 8);
    for (int i = 0; i < 12; i++) begin
      ram[(i + 8) % 10] = 8'(i * 59 + 28);
      xfer(1, LCDMX_DATA_OFF, {24'h0, ram[(i + 8) % 10]});
    end
    xfer(0, LCDMX_PTR_OFF, 0);
    chk("ptr", 0, rd);
    xfer(1, LCDMX_PTR_OFF, 9);
    xfer(0, LCDMX_DATA_OFF, 0);
    chk("data", {24'h0, ram[9]}, rd);
    xfer(0, LCDMX_DATA_OFF, 0);
    chk("data", {24'h0, ram[0]}, rd);
    xfer(1, LCDMX_CTRL_OFF, 32'h187);
    repeat (4000) @(posedge pclk);
    chk("pin", 1, vpin);
    for (int c = 0; c < 4; c++) begin
      for (int s = 0; s < 20; s++) begin
        chk("pixel", ram[s / 2][(s % 2) * 4 + c], pix[c * 20 + s]);
      end
    end
    frame(p80);
    xfer(1, LCDMX_CTRL_OFF, 32'h97);
    frame(p160);
    frame(p160);
    chk("frame", 1, p80 > 2 * p160 - 9 && p80 < 2 * p160 + 9);
    xfer(1, LCDMX_CTRL_OFF, 32'h8F);
    for (int k = 0; k < 16; k++) begin
      ram[k] = 8'(k * 71 + 13);
      xfer(1, LCDMX_DATA_OFF, {24'h0, ram[k]});
    end
    xfer(0, LCDMX_PTR_OFF, 0);
    chk("ptr", 0, rd);
    repeat (4000) @(posedge pclk);
    for (int c = 0; c < 8; c++) begin
      for (int s = 4; s < 20; s++) begin
        chk("pixel", ram[s - 4][c], pix[c * 20 + s]);
      end
    end
    chk("mode", 32'h0FF, {drive.bias_third, drive.com_active});
    frame(p8);
    frame(p8);
    chk("scan", 1, p8 > p80 - 9 && p8 < p80 + 9);
    // blink mode 1 first shows its blank half once 8192 fsys ticks have passed
    xfer(1, LCDMX_CTRL_OFF, 32'hAF);
    do xfer(0, LCDMX_STATUS_OFF, 0); while (rd[4] !== 1'b1);
    repeat (2) @(posedge pclk);
    chk("blink seg", 0, seg);
    chk("blink com", 1, !fs && $onehot(com));
    xfer(1, LCDMX_CTRL_OFF, 32'hCF);
    xfer(0, LCDMX_STATUS_OFF, 0);
    chk("blink2", 0, rd[4]);
    repeat (2) @(posedge pclk);
    chk("unblank", 1, seg != 20'h0);
    xfer(1, LCDMX_CTRL_OFF, 32'hEF);
    xfer(0, LCDMX_STATUS_OFF, 0);
    chk("blink3", 0, rd[4]);
    xfer(1, LCDMX_CTRL_OFF, 32'h80);
    repeat (4) @(posedge pclk);
    chk("off", 32'h1FF, {fs, com});
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    xfer(0, LCDMX_CTRL_OFF, 0);
    chk("ctrl", 32'h80, rd);
    report_and_stop;
  end
endmodule
`default_nettype wire
